// ===== rtl/run_sync_cfg.svh
// Offsets, field positions, reset values and fixed sizes of the run-control block.
// Included by the run-control modules; definitions only.
`ifndef RUN_SYNC_CFG_SVH
`define RUN_SYNC_CFG_SVH
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_SYNC_N 4'h2
`define REG_PIX_RUN 4'h3
`define REG_PIX_BUF 4'h4
`define REG_SPEC_LEN 4'h5
`define REG_STATUS 4'h6
`define REG_PIX_CNT 4'h7
`define REG_BUF_CNT 4'h8
`define CTRL_MODE_LSB 0
`define CTRL_POL 2
`define CTRL_ADV_ONLY 3
`define CTRL_SYNC_FALL 4
`define CTRL_START_MASTER 5
`define CTRL_READY_OUT 6
`define CTRL_HOLD_MASTER 7
`define CTRL_SYNC_MASTER 8
`define CTRL_MAP_EN 9
`define CMD_START 0
`define CMD_STOP 1
`define CMD_ADVANCE 2
`define CMD_READ_DONE 3
`define CTRL_RESET 32'h0000_0000
`define SYNC_N_RESET 32'h0000_0001
`define PIX_RUN_RESET 32'hffff_ffff
`define PIX_BUF_RESET 32'h0000_0000
`define SPEC_LEN_RESET 32'h0000_0800
`define MEM_WORDS 32'h0010_0000
`define BUF_MARGIN 32'h0000_0002
`endif

// ===== rtl/run_sync_pkg.sv
// Types shared by the run-control modules.
// Holds no constants; those live in run_sync_cfg.svh.
package run_sync_pkg;
   typedef enum logic [1:0] {
      adv_gate = 2'h0,
      adv_sync = 2'h1,
      adv_host = 2'h2
   } adv_mode_e;
   typedef enum logic [2:0] {
      st_idle = 3'h1,
      st_run = 3'h2,
      st_done = 3'h4
   } run_state_e;
endpackage

// ===== rtl/edge_bus_if.sv
// Carries the sampled hold level (front-panel or backplane pin) and the hold and sync edge events between modules.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface edge_bus_if;
   logic hold_active;
   logic hold_lead;
   logic sync_edge;
   modport src(output hold_active, output hold_lead, output sync_edge);
   modport dst(input hold_active, input hold_lead, input sync_edge);
endinterface

// ===== rtl/pin_edges.sv
// Registers the hold and sync pins and derives the halting level and edge pulses.
// Assumes the pins are already synchronous to clk.
`timescale 1ns/10ps
module pin_edges (
   input wire logic clk,
   input wire logic reset,
   input wire logic hold_pin,
   input wire logic sync_pin,
   input wire logic halt_on_high,
   input wire logic sync_on_fall,
   edge_bus_if.src eb
);
   logic hold_q;
   logic hold_q2;
   logic sync_q;
   logic sync_q2;
   logic next_hold_q;
   logic next_sync_q;
   always_comb begin
      next_hold_q = hold_pin;
      next_sync_q = sync_pin;
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         hold_q <= 1'b0;
         hold_q2 <= 1'b0;
         sync_q <= 1'b0;
         sync_q2 <= 1'b0;
      end else begin
         hold_q <= next_hold_q;
         hold_q2 <= hold_q;
         sync_q <= next_sync_q;
         sync_q2 <= sync_q;
      end
   end
   // The halting level is chosen by one polarity bit, and the leading edge is the
   // transition into that level, so both meanings follow the same setting.
   assign eb.hold_active = hold_q ~^ halt_on_high;
   assign eb.hold_lead = (hold_q ~^ halt_on_high) & ~(hold_q2 ~^ halt_on_high);
   assign eb.sync_edge = sync_on_fall ? (~sync_q & sync_q2) : (sync_q & ~sync_q2);
endmodule

// ===== rtl/run_sync_ctrl.sv
// Run control: start, hold gating, pixel advance, run stop and buffer swap.
// Assumes a classic Wishbone master on clk and pins synchronous to clk.
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "run_sync_cfg.svh"
module run_sync_ctrl (
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic seg_start_in,
   output logic seg_start_out,
   input wire logic start_line_in,
   output logic start_line_out,
   output logic start_line_oe_n,
   input wire logic hold_front,
   input wire logic hold_backplane,
   input wire logic sync_front,
   input wire logic sync_backplane,
   output logic acquire_enable,
   output logic pixel_advance,
   output logic active_buffer,
   output logic buffer_swap,
   output logic run_active
);
   logic [31:0] ctrl;
   logic [31:0] sync_n;
   logic [31:0] pix_run;
   logic [31:0] pix_buf;
   logic [31:0] spec_len;
   logic [31:0] pix_cnt;
   logic [31:0] buf_cnt;
   logic [31:0] sync_cnt;
   logic buf_full_pending;
   run_sync_pkg::run_state_e state;
   run_sync_pkg::run_state_e next_state;
   logic [31:0] next_ctrl;
   logic [31:0] next_sync_n;
   logic [31:0] next_pix_run;
   logic [31:0] next_pix_buf;
   logic [31:0] next_spec_len;
   logic [31:0] next_pix_cnt;
   logic [31:0] next_buf_cnt;
   logic [31:0] next_sync_cnt;
   logic next_buf_full_pending;
   logic [31:0] next_dat_o;
   logic next_ack;
   logic next_start_out;
   logic next_line_out;
   logic next_line_oe_n;
   logic next_acquire;
   logic next_advance;
   logic next_active_buffer;
   logic next_swap;
   logic next_run_active;
   logic wr;
   logic rd;
   logic cmd_start;
   logic cmd_stop;
   logic cmd_adv;
   logic cmd_read_done;
   logic start_req;
   logic adv_event;
   logic [31:0] buf_limit;
   logic [31:0] buf_max;
   logic hold_pin;
   logic sync_pin;
   run_sync_pkg::adv_mode_e mode;
   edge_bus_if eb();

   // Largest pixel count that still fits one buffer, kept a little below the ratio.
   function automatic logic [31:0] max_pixels(input logic [31:0] len);
      logic [31:0] q;
      q = (len == 32'h0) ? `MEM_WORDS : (`MEM_WORDS / len);
      max_pixels = (q > `BUF_MARGIN) ? q - `BUF_MARGIN : 32'h1;
   endfunction

   function automatic logic reg_hit(input logic [5:0] adr, input logic [3:0] idx);
      reg_hit = (adr[5:2] == idx) && (adr[1:0] == 2'h0);
   endfunction

   // Masters take the front-panel pin; other modules follow the backplane copy.
   assign hold_pin = ctrl[`CTRL_HOLD_MASTER] ? hold_front : hold_backplane;
   assign sync_pin = ctrl[`CTRL_SYNC_MASTER] ? sync_front : sync_backplane;
   assign mode = run_sync_pkg::adv_mode_e'(ctrl[`CTRL_MODE_LSB +: 2]);

   // The edge detector sees the pin after the master selection, so moving a master bit
   // during a run can look like an edge; set the master bits between runs.
   pin_edges u_pin_edges (
      .clk(clk),
      .reset(reset),
      .hold_pin(hold_pin),
      .sync_pin(sync_pin),
      .halt_on_high(ctrl[`CTRL_POL]),
      .sync_on_fall(ctrl[`CTRL_SYNC_FALL]),
      .eb(eb.src)
   );

   // The divide is plain combinational logic from the spectrum length; it trades clock
   // headroom for having the effective limit ready in the cycle after a write.
   assign buf_max = max_pixels(spec_len);
   assign buf_limit = (pix_buf == 32'h0 || pix_buf > buf_max) ? buf_max : pix_buf;

   always_comb begin
      // Requests are taken only while ack is low, so a command acts exactly once.
      wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
      rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
      cmd_start = wr & reg_hit(wb_adr_i, `REG_CMD) & wb_sel_i[0] & wb_dat_i[`CMD_START];
      cmd_stop = wr & reg_hit(wb_adr_i, `REG_CMD) & wb_sel_i[0] & wb_dat_i[`CMD_STOP];
      cmd_adv = wr & reg_hit(wb_adr_i, `REG_CMD) & wb_sel_i[0] & wb_dat_i[`CMD_ADVANCE];
      cmd_read_done = wr & reg_hit(wb_adr_i, `REG_CMD) & wb_sel_i[0]
         & wb_dat_i[`CMD_READ_DONE];
      // A segment start comes from the host, the shared segment line, or the
      // cross-segment line when this module is that segment's start master without ready output.
      start_req = cmd_start | seg_start_in
         | (ctrl[`CTRL_START_MASTER] & ~ctrl[`CTRL_READY_OUT] & start_line_in);
      // Advances count only inside a run with mapping enabled; in single-spectrum runs
      // the hold pin only gates acquisition and its edges are ignored.
      adv_event = 1'b0;
      if (state == run_sync_pkg::st_run) begin
         case (mode)
            run_sync_pkg::adv_gate: adv_event = eb.hold_lead;
            run_sync_pkg::adv_sync: adv_event = eb.sync_edge && (sync_cnt + 32'h1 >= sync_n);
            run_sync_pkg::adv_host: adv_event = cmd_adv;
            default: adv_event = 1'b0;
         endcase
         adv_event = adv_event & ctrl[`CTRL_MAP_EN];
      end
   end

   // Register file: write strobes with byte lanes, single-cycle ack, zero elsewhere.
   function automatic logic [31:0] lane_write(input logic [31:0] old,
         input logic [31:0] din, input logic [3:0] sel);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            v[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      lane_write = v;
   endfunction

   always_comb begin
      next_ctrl = ctrl;
      next_sync_n = sync_n;
      next_pix_run = pix_run;
      next_pix_buf = pix_buf;
      next_spec_len = spec_len;
      next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      next_dat_o = 32'h0;
      if (wr && reg_hit(wb_adr_i, `REG_CTRL)) begin
         next_ctrl = lane_write(ctrl, wb_dat_i, wb_sel_i);
      end
      if (wr && reg_hit(wb_adr_i, `REG_SYNC_N)) begin
         next_sync_n = lane_write(sync_n, wb_dat_i, wb_sel_i);
      end
      if (wr && reg_hit(wb_adr_i, `REG_PIX_RUN)) begin
         next_pix_run = lane_write(pix_run, wb_dat_i, wb_sel_i);
      end
      if (wr && reg_hit(wb_adr_i, `REG_PIX_BUF)) begin
         next_pix_buf = lane_write(pix_buf, wb_dat_i, wb_sel_i);
      end
      if (wr && reg_hit(wb_adr_i, `REG_SPEC_LEN)) begin
         next_spec_len = lane_write(spec_len, wb_dat_i, wb_sel_i);
      end
      if (rd) begin
         case (wb_adr_i[5:2])
            `REG_CTRL: next_dat_o = ctrl;
            `REG_SYNC_N: next_dat_o = sync_n;
            `REG_PIX_RUN: next_dat_o = pix_run;
            // Software reads back the pixel count in force, so a substituted maximum shows.
            `REG_PIX_BUF: next_dat_o = buf_limit;
            `REG_SPEC_LEN: next_dat_o = spec_len;
            `REG_STATUS: next_dat_o = {24'h0, 1'b0, buf_full_pending, active_buffer,
               acquire_enable, 1'b0, state};
            `REG_PIX_CNT: next_dat_o = pix_cnt;
            `REG_BUF_CNT: next_dat_o = buf_cnt;
            default: next_dat_o = 32'h0;
         endcase
      end
   end

   // Run sequencing, pixel counting and buffer alternation.
   always_comb begin
      next_state = state;
      next_pix_cnt = pix_cnt;
      next_buf_cnt = buf_cnt;
      next_sync_cnt = sync_cnt;
      next_buf_full_pending = buf_full_pending;
      next_active_buffer = active_buffer;
      next_swap = 1'b0;
      next_advance = adv_event;
      next_start_out = 1'b0;
      case (state)
         run_sync_pkg::st_idle: begin
            if (start_req) begin
               next_state = run_sync_pkg::st_run;
               next_start_out = 1'b1;
               next_pix_cnt = 32'h0;
               next_buf_cnt = 32'h0;
               next_sync_cnt = 32'h0;
               // The fill memory carries over between runs, so it only ever changes
               // together with a swap pulse and readout never loses track of it.
               next_buf_full_pending = 1'b0;
            end
         end
         run_sync_pkg::st_run: begin
            // Lowering N in mid-pixel to the count reached or below makes the very next counted edge advance, since
            // the count reached is compared against N rather than matched exactly.
            if (eb.sync_edge && mode == run_sync_pkg::adv_sync) begin
               next_sync_cnt = sync_cnt + 32'h1;
            end
            if (adv_event) begin
               next_sync_cnt = 32'h0;
               next_pix_cnt = pix_cnt + 32'h1;
               if (buf_cnt + 32'h1 >= buf_limit) begin
                  // Swap to the other memory; the full one waits for readout.
                  next_buf_cnt = 32'h0;
                  next_active_buffer = ~active_buffer;
                  next_swap = 1'b1;
                  next_buf_full_pending = 1'b1;
               end else begin
                  next_buf_cnt = buf_cnt + 32'h1;
               end
               // The all-ones limit never stops; any other value ends the run after that many
               // pixels, and zero ends it after the first pixel.
               if (pix_run != 32'hffff_ffff && pix_cnt + 32'h1 >= pix_run) begin
                  next_state = run_sync_pkg::st_done;
               end
            end
            if (cmd_stop) begin
               next_state = run_sync_pkg::st_done;
            end
         end
         run_sync_pkg::st_done: begin
            next_state = run_sync_pkg::st_idle;
         end
         default: next_state = run_sync_pkg::st_idle;
      endcase
      // A new full buffer outranks a readout acknowledge in the same cycle, so software
      // can never clear a buffer that it has not yet been told about.
      if (cmd_read_done && !next_swap) begin
         next_buf_full_pending = 1'b0;
      end
   end

   always_comb begin
      next_run_active = (next_state == run_sync_pkg::st_run);
      // Hold gating applies in every mode except gate mode with advance-only and mapping set;
      // a hold at run start simply keeps acquisition off until released.
      next_acquire = next_run_active;
      if (eb.hold_active && !(mode == run_sync_pkg::adv_gate && ctrl[`CTRL_ADV_ONLY]
            && ctrl[`CTRL_MAP_EN])) begin
         next_acquire = 1'b0;
      end
      // As a ready output the line is driven with the run state; otherwise the
      // master drives the start pulse onto it.
      next_line_oe_n = 1'b1;
      next_line_out = 1'b0;
      if (ctrl[`CTRL_START_MASTER]) begin
         if (ctrl[`CTRL_READY_OUT]) begin
            next_line_oe_n = 1'b0;
            next_line_out = (state == run_sync_pkg::st_idle);
         end else if (cmd_start) begin
            next_line_oe_n = 1'b0;
            next_line_out = 1'b1;
         end
      end
   end

   // Every output leaves a flip-flop, so the block's outputs may drive pins directly.
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= `CTRL_RESET;
         sync_n <= `SYNC_N_RESET;
         pix_run <= `PIX_RUN_RESET;
         pix_buf <= `PIX_BUF_RESET;
         spec_len <= `SPEC_LEN_RESET;
         state <= run_sync_pkg::st_idle;
         pix_cnt <= 32'h0;
         buf_cnt <= 32'h0;
         sync_cnt <= 32'h0;
         buf_full_pending <= 1'b0;
         wb_dat_o <= 32'h0;
         wb_ack_o <= 1'b0;
         seg_start_out <= 1'b0;
         start_line_out <= 1'b0;
         start_line_oe_n <= 1'b1;
         acquire_enable <= 1'b0;
         pixel_advance <= 1'b0;
         active_buffer <= 1'b0;
         buffer_swap <= 1'b0;
         run_active <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         sync_n <= next_sync_n;
         pix_run <= next_pix_run;
         pix_buf <= next_pix_buf;
         spec_len <= next_spec_len;
         state <= next_state;
         pix_cnt <= next_pix_cnt;
         buf_cnt <= next_buf_cnt;
         sync_cnt <= next_sync_cnt;
         buf_full_pending <= next_buf_full_pending;
         wb_dat_o <= next_dat_o;
         wb_ack_o <= next_ack;
         seg_start_out <= next_start_out;
         start_line_out <= next_line_out;
         start_line_oe_n <= next_line_oe_n;
         acquire_enable <= next_acquire;
         pixel_advance <= next_advance;
         active_buffer <= next_active_buffer;
         buffer_swap <= next_swap;
         run_active <= next_run_active;
      end
   end
endmodule

// ===== tb/run_sync_ctrl_sva.sv
// Port checker for the run-control block.
// Sees only the top module's ports; bound to it below.
`timescale 1ns/10ps
module run_sync_ctrl_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic start_line_oe_n,
   input wire logic seg_start_out,
   input wire logic acquire_enable,
   input wire logic pixel_advance,
   input wire logic active_buffer,
   input wire logic buffer_swap,
   input wire logic run_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   adv_pulse_a: assert property (pixel_advance |=> !pixel_advance)
      else $error("pixel advance longer than one cycle");
   adv_in_run_a: assert property (pixel_advance |-> run_active || $past(run_active))
      else $error("pixel advance outside a run");
   acq_in_run_a: assert property (acquire_enable |-> run_active)
      else $error("acquiring outside a run");
   start_edge_a: assert property (seg_start_out |-> run_active && !$past(run_active))
      else $error("start pulse not at run start");
   swap_link_a: assert property ($changed(active_buffer) |-> buffer_swap || $past(buffer_swap))
      else $error("fill memory changed without swap pulse");
   release_idle_a: assert property ($fell(reset) |-> start_line_oe_n && !run_active)
      else $error("start line driven or run active after reset");
endmodule
bind run_sync_ctrl run_sync_ctrl_sva i_run_sync_ctrl_sva (
   .clk(clk),
   .reset(reset),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .start_line_oe_n(start_line_oe_n),
   .seg_start_out(seg_start_out),
   .acquire_enable(acquire_enable),
   .pixel_advance(pixel_advance),
   .active_buffer(active_buffer),
   .buffer_swap(buffer_swap),
   .run_active(run_active)
);

// ===== tb/gate_sync_gen.sv
// Model of the user's gate level source and sync clock generator.
// Assumes the bench changes its requests right after rising edges of clk.
`timescale 1ns/10ps
module gate_sync_gen (
   input wire logic clk,
   input wire logic hold_req,
   input wire logic sync_en,
   output logic hold_pin,
   output logic sync_pin
);
   logic [1:0] phase = 2'h0;
   // The gate may sit at its halting level at run start to delay acquisition.
   always_ff @(posedge clk) begin
      hold_pin <= hold_req;
   end
   // The sync clock finishes its period and then stands still low between bursts.
   always_ff @(posedge clk) begin
      if (sync_en || phase != 2'h0) begin
         phase <= phase + 2'h1;
      end
   end
   assign sync_pin = phase[1];
endmodule

// ===== tb/run_sync_ctrl_tb_top.sv
// Self-checking bench for the run-control block, driven over classic Wishbone.
// Assumes the gate/sync model and the bound port checker are compiled alongside.
`timescale 1ns/10ps
`include "run_sync_cfg.svh"
module run_sync_ctrl_tb_top;
   localparam logic [31:0] buf_max = `MEM_WORDS / `SPEC_LEN_RESET - `BUF_MARGIN;
   logic clk, reset, cyc, stb, we, hold_req, sync_en, hold_pin, sync_pin;
   logic ack, acq, adv, abuf, swap, run, sso, slo, oe_n;
   logic [5:0] adr;
   logic [31:0] dat, rd, dat_o;
   logic [3:0] sel;
   logic seg_in, line_in, hold_bp, sync_bp;
   int miscompares = 0;
   int comparisons = 0;
   int adv_count = 0;
   int swap_count = 0;
   int sso_count = 0;
   int line_count = 0;
   gate_sync_gen i_gate_sync_gen (.clk(clk), .hold_req(hold_req), .sync_en(sync_en),
      .hold_pin(hold_pin), .sync_pin(sync_pin));
   run_sync_ctrl i_run_sync_ctrl (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .seg_start_in(seg_in), .seg_start_out(sso), .start_line_in(line_in),
      .start_line_out(slo), .start_line_oe_n(oe_n), .hold_front(hold_pin),
      .hold_backplane(hold_bp), .sync_front(sync_pin), .sync_backplane(sync_bp),
      .acquire_enable(acq), .pixel_advance(adv), .active_buffer(abuf),
      .buffer_swap(swap), .run_active(run));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pulses are counted mid-cycle, where they are settled.
   always @(negedge clk) begin
      if (adv === 1'b1) adv_count++;
      if (swap === 1'b1) swap_count++;
      if (sso === 1'b1) sso_count++;
      if (oe_n === 1'b0 && slo === 1'b1) line_count++;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // The request stands until the rising edge at which ack is seen high; read data is
   // taken at that edge and the request is released there, by non-blocking assignment.
   task wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= {idx, 2'h0};
      dat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
   endtask
   task rd_chk(input logic [3:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 32'h0);
      check(rd, exp);
   endtask
   task wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task pin(input logic v);
      @(posedge clk);
      hold_req <= v;
      wait_cyc(8);
   endtask
   task finish_test;
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      finish_test;
   end
   initial begin
      reset = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 6'h0;
      dat = 32'h0;
      hold_req = 1'b0;
      sync_en = 1'b0;
      sel = 4'h0;
      seg_in = 1'b0;
      line_in = 1'b0;
      hold_bp = 1'b0;
      sync_bp = 1'b0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd_chk(`REG_CTRL, `CTRL_RESET);
      rd_chk(`REG_SYNC_N, `SYNC_N_RESET);
      rd_chk(`REG_PIX_RUN, `PIX_RUN_RESET);
      rd_chk(`REG_PIX_BUF, buf_max);
      rd_chk(4'hf, 32'h0);
      rd_chk(`REG_STATUS, 32'h1);
      $display("test reset values done");
      // Gate mode, low halts, gate held low at start, three pixels per run.
      wb(1'b1, `REG_CTRL, 32'h380);
      wb(1'b1, `REG_PIX_RUN, 32'h3);
      wb(1'b1, `REG_CMD, 32'h1);
      wait_cyc(4);
      check(run, 1'b1);
      check(acq, 1'b0);
      check(sso_count, 1);
      pin(1'b1);
      check(acq, 1'b1);
      check(adv_count, 0);
      repeat (3) begin
         pin(1'b0);
         check(acq, 1'b0);
         pin(1'b1);
      end
      check(adv_count, 3);
      check(run, 1'b0);
      $display("test gate mode done");
      // High halts with advance only, and a run that never stops by itself.
      adv_count = 0;
      wb(1'b1, `REG_CTRL, 32'h38c);
      wb(1'b1, `REG_PIX_RUN, 32'hffffffff);
      wb(1'b1, `REG_CMD, 32'h1);
      wait_cyc(4);
      check(acq, 1'b1);
      repeat (4) begin
         pin(1'b0);
         pin(1'b1);
      end
      check(adv_count, 4);
      check(run, 1'b1);
      wb(1'b1, `REG_CMD, 32'h2);
      wait_cyc(3);
      check(run, 1'b0);
      $display("test advance only done");
      // Sync mode, three edges a pixel, two pixels a buffer.
      adv_count = 0;
      wb(1'b1, `REG_CTRL, 32'h381);
      wb(1'b1, `REG_SYNC_N, 32'h3);
      wb(1'b1, `REG_PIX_BUF, 32'h1000);
      rd_chk(`REG_PIX_BUF, buf_max);
      wb(1'b1, `REG_PIX_BUF, 32'h2);
      rd_chk(`REG_PIX_BUF, 32'h2);
      wb(1'b1, `REG_CMD, 32'h1);
      @(posedge clk);
      sync_en <= 1'b1;
      repeat (24) @(posedge clk);
      sync_en <= 1'b0;
      wait_cyc(8);
      check(adv_count, 2);
      check(swap_count, 1);
      check(abuf, 1'b1);
      rd_chk(`REG_STATUS, 32'h72);
      rd_chk(`REG_BUF_CNT, 32'h0);
      wb(1'b1, `REG_CMD, 32'h8);
      rd_chk(`REG_STATUS, 32'h32);
      wb(1'b1, `REG_CMD, 32'h2);
      $display("test sync mode done");
      // Host mode: gate edges are ignored, the command advances.
      adv_count = 0;
      wb(1'b1, `REG_CTRL, 32'h382);
      wb(1'b1, `REG_CMD, 32'h1);
      pin(1'b0);
      pin(1'b1);
      check(adv_count, 0);
      wb(1'b1, `REG_CMD, 32'h4);
      wait_cyc(4);
      check(adv_count, 1);
      wb(1'b1, `REG_CMD, 32'h2);
      $display("test host mode done");
      // Backplane copies, a segment start and the cross-segment line as ready output.
      adv_count = 0;
      wb(1'b1, `REG_CTRL, 32'h261);
      wait_cyc(2);
      check(oe_n, 1'b0);
      check(slo, 1'b1);
      @(posedge clk);
      seg_in <= 1'b1;
      @(posedge clk);
      seg_in <= 1'b0;
      wait_cyc(3);
      check(run, 1'b1);
      check(slo, 1'b0);
      check(acq, 1'b0);
      @(posedge clk);
      hold_bp <= 1'b1;
      @(posedge clk);
      sync_en <= 1'b1;
      repeat (12) @(posedge clk);
      sync_en <= 1'b0;
      wait_cyc(4);
      check(acq, 1'b1);
      check(adv_count, 0);
      repeat (3) begin
         @(posedge clk);
         sync_bp <= 1'b1;
         @(posedge clk);
         sync_bp <= 1'b0;
      end
      wait_cyc(4);
      check(adv_count, 1);
      wb(1'b1, `REG_CMD, 32'h2);
      // Start master without ready output: drives the start pulse and accepts the line.
      wb(1'b1, `REG_CTRL, 32'h220);
      line_count = 0;
      wb(1'b1, `REG_CMD, 32'h1);
      wait_cyc(2);
      check(line_count, 1);
      wb(1'b1, `REG_CMD, 32'h2);
      wait_cyc(2);
      check(run, 1'b0);
      @(posedge clk);
      line_in <= 1'b1;
      @(posedge clk);
      line_in <= 1'b0;
      wait_cyc(3);
      check(run, 1'b1);
      wb(1'b1, `REG_CMD, 32'h2);
      $display("test segment lines done");
      finish_test;
   end
endmodule
